// ===== src/bidir_port.sv
// eight-pin bidirectional port with direction, latch, analog select and wishbone access
// assumes pads resolve the wire from pad_out_o and pad_oe_n_o; one clock, no interrupts
`timescale 1ns/1ns
`default_nettype none
// Operation
// R01: eight pins, each independently usable as digital input or output.
// R02: direction bit 1 makes pin input, output driver high impedance.
// R03: direction bit 0 enables driver, pin shows output latch bit.
// R04: port data read returns pin levels; write goes into output latch.
// R05: writes are read-modify-write: sampled pins, modified, stored into latch.
// R06: direction bits control drivers even for analog-selected pins.
// R07: software keeps direction at input for analog pins.
// R08: analog-selected pin reads digital zero; analog functions may operate.
// R09: analog select never affects digital output drive.
// R10: after reset all analog select bits are in analog setting.
// R11: software clears analog select before using pin as digital input.
// R12: with several enabled output sources, highest priority source drives pin.
module bidir_port (
  input wire logic clk_i, // system clock, 25 MHz
  input wire logic rst_i, // async reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic wb_err_o, // unmapped address answer
  input wire logic [7:0] pad_in_i, // pin levels from pads
  output logic [7:0] pad_out_o, // pin drive levels
  output logic [7:0] pad_oe_n_o, // output enable, low drives pin
  output logic [7:0] analog_en_o // analog function enable per pin
);
  gpio_pkg::wb_req_s req;
  gpio_pkg::bus_state_e bus_state_reg;
  gpio_pkg::bus_state_e bus_state_next;
  logic [7:0] direction_reg;
  logic [7:0] direction_next;
  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] analog_reg;
  logic [7:0] analog_next;
  logic [7:0] periph_en_reg;
  logic [7:0] periph_en_next;
  logic [7:0] periph_dat_reg;
  logic [7:0] periph_dat_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [7:0] pin_sync_lvl;
  logic [7:0] pin_read;
  gpio_pkg::drive_s gpio_src;
  gpio_pkg::drive_s periph_src;
  gpio_pkg::drive_s pin_drive;
  logic access;
  logic hit;
  logic wr_take; // write request taken this cycle
  logic rd_take; // read request taken this cycle
  logic wr_pin_data; // write strobe, pin data register
  logic wr_direction; // write strobe, direction register
  logic wr_latch; // write strobe, output latch
  logic wr_analog; // write strobe, analog select
  logic wr_periph_en; // write strobe, peripheral enable
  logic wr_periph_dat; // write strobe, peripheral data

  // merge byte lane 0 of write data into an old value when selected
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                       input logic [31:0] dat);
    lane0 = sel[0] ? dat[7:0] : old;
  endfunction : lane0

  // decide whether an address is mapped
  function automatic logic mapped(input logic [7:0] adr);
    if (adr == gpio_pkg::OFF_PIN_DATA) begin
      mapped = 1'b1;
    end else if (adr == gpio_pkg::OFF_DIRECTION) begin
      mapped = 1'b1;
    end else if (adr == gpio_pkg::OFF_OUTPUT_LATCH) begin
      mapped = 1'b1;
    end else if (adr == gpio_pkg::OFF_ANALOG_SELECT) begin
      mapped = 1'b1;
    end else if (adr == gpio_pkg::OFF_PERIPH_ENABLE) begin
      mapped = 1'b1;
    end else if (adr == gpio_pkg::OFF_PERIPH_DATA) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction : mapped

  // pack the bus request
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  // pins pass two flip-flops before any logic reads them
  pin_sync u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pad_in_i),
    .pin_o(pin_sync_lvl)
  );

  // digital read path: analog-selected pins read as zero
  assign pin_read = pin_sync_lvl & ~analog_reg; // R08

  // output sources: peripheral overrides plain port data
  always_comb begin
    gpio_src.en = ~direction_reg; // R02 R03 R06 R09
    gpio_src.dat = latch_reg; // R03
    periph_src.en = periph_en_reg & ~direction_reg; // R06
    periph_src.dat = periph_dat_reg;
    for (int i = 0; i < gpio_pkg::PORT_WIDTH; i++) begin // R01
      if (periph_src.en[i]) begin
        pin_drive.en[i] = 1'b1; // R12
        pin_drive.dat[i] = periph_src.dat[i]; // R12
      end else begin
        pin_drive.en[i] = gpio_src.en[i];
        pin_drive.dat[i] = gpio_src.dat[i];
      end
    end
  end

  // pad drive outputs from registers
  assign pad_out_o = pin_drive.dat;
  assign pad_oe_n_o = ~pin_drive.en; // R02 R03
  assign analog_en_o = analog_reg; // R08

  // a new access is a request not yet acknowledged
  assign access = req.cyc && req.stb && (bus_state_reg == gpio_pkg::BUS_IDLE);
  assign hit = mapped(req.adr);

  // split a taken request by direction
  assign wr_take = access && req.we;
  assign rd_take = access && !req.we;

  // write strobes: one per register, an unmapped write raises none
  always_comb begin
    wr_pin_data = 1'b0;
    wr_direction = 1'b0;
    wr_latch = 1'b0;
    wr_analog = 1'b0;
    wr_periph_en = 1'b0;
    wr_periph_dat = 1'b0;
    if (wr_take) begin
      if (req.adr == gpio_pkg::OFF_PIN_DATA) begin
        wr_pin_data = 1'b1;
      end else if (req.adr == gpio_pkg::OFF_DIRECTION) begin
        wr_direction = 1'b1;
      end else if (req.adr == gpio_pkg::OFF_OUTPUT_LATCH) begin
        wr_latch = 1'b1;
      end else if (req.adr == gpio_pkg::OFF_ANALOG_SELECT) begin
        wr_analog = 1'b1;
      end else if (req.adr == gpio_pkg::OFF_PERIPH_ENABLE) begin
        wr_periph_en = 1'b1;
      end else if (req.adr == gpio_pkg::OFF_PERIPH_DATA) begin
        wr_periph_dat = 1'b1;
      end
    end
  end

  // bus handshake: one answer per taken request, no new request taken while it is shown
  always_comb begin
    bus_state_next = bus_state_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    case (bus_state_reg)
      gpio_pkg::BUS_IDLE: begin
        if (access) begin
          bus_state_next = gpio_pkg::BUS_ACK;
          ack_next = hit;
          err_next = ~hit;
        end
      end
      gpio_pkg::BUS_ACK: begin
        // no request is taken in the cycle the answer is shown, so a held strobe is not taken twice
        bus_state_next = gpio_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_next = gpio_pkg::BUS_IDLE;
      end
    endcase
  end

  // register the handshake state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state_reg <= gpio_pkg::BUS_IDLE;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  // read data: cleared on every taken request, loaded on reads
  always_comb begin
    rdata_next = rdata_reg;
    if (access) begin
      rdata_next = 32'h0000_0000;
    end
    if (rd_take) begin
      if (req.adr == gpio_pkg::OFF_PIN_DATA) begin
        rdata_next = {24'h000000, pin_read}; // R04 R08
      end else if (req.adr == gpio_pkg::OFF_DIRECTION) begin
        rdata_next = {24'h000000, direction_reg};
      end else if (req.adr == gpio_pkg::OFF_OUTPUT_LATCH) begin
        rdata_next = {24'h000000, latch_reg};
      end else if (req.adr == gpio_pkg::OFF_ANALOG_SELECT) begin
        rdata_next = {24'h000000, analog_reg};
      end else if (req.adr == gpio_pkg::OFF_PERIPH_ENABLE) begin
        rdata_next = {24'h000000, periph_en_reg};
      end else if (req.adr == gpio_pkg::OFF_PERIPH_DATA) begin
        rdata_next = {24'h000000, periph_dat_reg};
      end
    end
  end

  // register the read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // direction next value: selected lane replaces the old bits
  always_comb begin
    direction_next = direction_reg;
    if (wr_direction) begin
      direction_next = lane0(direction_reg, req.sel, req.dat);
    end
  end

  // register the direction bits, all inputs after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      direction_reg <= gpio_pkg::RST_DIRECTION; // R02
    end else begin
      direction_reg <= direction_next;
    end
  end

  // output latch next value: pin data writes sample the pins first
  always_comb begin
    latch_next = latch_reg;
    if (wr_pin_data) begin
      // read-modify-write: unselected lane keeps sampled pin levels
      latch_next = lane0(pin_read, req.sel, req.dat); // R04 R05
    end else if (wr_latch) begin
      latch_next = lane0(latch_reg, req.sel, req.dat);
    end
  end

  // register the output latch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_reg <= gpio_pkg::RST_OUTPUT_LATCH;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // analog select next value
  always_comb begin
    analog_next = analog_reg;
    if (wr_analog) begin
      analog_next = lane0(analog_reg, req.sel, req.dat);
    end
  end

  // register analog select, analog mode after any reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_reg <= gpio_pkg::RST_ANALOG_SELECT; // R10
    end else begin
      analog_reg <= analog_next;
    end
  end

  // peripheral source next values
  always_comb begin
    periph_en_next = periph_en_reg;
    periph_dat_next = periph_dat_reg;
    if (wr_periph_en) begin
      periph_en_next = lane0(periph_en_reg, req.sel, req.dat);
    end
    if (wr_periph_dat) begin
      periph_dat_next = lane0(periph_dat_reg, req.sel, req.dat);
    end
  end

  // register the peripheral source, disabled after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      periph_en_reg <= gpio_pkg::RST_PERIPH_ENABLE;
      periph_dat_reg <= gpio_pkg::RST_PERIPH_DATA;
    end else begin
      periph_en_reg <= periph_en_next;
      periph_dat_reg <= periph_dat_next;
    end
  end

  // bus answers come from flip-flops
  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
endmodule : bidir_port
`default_nettype wire

// ===== src/gpio_pkg.sv
// package for the eight-pin bidirectional port: register map, reset values, carriers
// assumes a classic wishbone slave with 32-bit data and byte addresses
package gpio_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam logic [7:0] OFF_PIN_DATA = 8'h00;
  localparam logic [7:0] OFF_DIRECTION = 8'h04;
  localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h08;
  localparam logic [7:0] OFF_ANALOG_SELECT = 8'h0C;
  localparam logic [7:0] OFF_PERIPH_ENABLE = 8'h10;
  localparam logic [7:0] OFF_PERIPH_DATA = 8'h14;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_ANALOG_SELECT = 8'hFF;
  localparam logic [7:0] RST_PERIPH_ENABLE = 8'h00;
  localparam logic [7:0] RST_PERIPH_DATA = 8'h00;
  localparam int unsigned SYNC_STAGES = 2;

  // wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  // per-pin drive request from one output source
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] dat;
  } drive_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;
endpackage : gpio_pkg

// ===== src/pin_sync.sv
// two-stage synchroniser for the eight pin levels
// assumes pins change asynchronously to clk_i
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic [7:0] pin_i, // raw pin levels
  output logic [7:0] pin_o // synchronised levels
);
  logic [7:0] meta_reg;
  logic [7:0] meta_next;
  logic [7:0] sync_reg;
  logic [7:0] sync_next;

  // next values: first stage feeds only the second
  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;
  end

  // register both stages
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_o = sync_reg;
endmodule : pin_sync
`default_nettype wire

// ===== verif/bidir_port_sva.sv
// checker for the eight-pin port: bus answers, pin drive, analog select
// assumes one clock and the single-cycle wishbone answer of the slave
`timescale 1ns/1ns
`default_nettype none
module bidir_port_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // selects
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic wb_err_o, // error
  input wire logic [7:0] pad_in_i, // pins in
  input wire logic [7:0] pad_out_o, // pins out
  input wire logic [7:0] pad_oe_n_o, // drive enable, low drives
  input wire logic [7:0] analog_en_o // analog enable
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  // address decode of the six registers
  assign mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  sequence idle_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence taken(logic [7:0] a, logic w);
    idle_req ##0 (wb_adr_i == a && wb_we_i == w);
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  one_answer_a: assert property (idle_req |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
  no_spurious_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o) else $error("answer unasked");
  unmapped_a: assert property (idle_req ##0 !mapped |=> wb_err_o && wb_dat_o == 32'h0) else $error("unmapped");
  dir_drive_a: assert property (taken(8'h04, 1'b1) ##0 wb_sel_i[0] |=>
    pad_oe_n_o == $past(wb_dat_i[7:0])) else $error("direction not on drivers");
  analog_write_a: assert property (taken(8'h0C, 1'b1) ##0 wb_sel_i[0] |=>
    analog_en_o == $past(wb_dat_i[7:0]) && $stable(pad_out_o) && $stable(pad_oe_n_o)) else $error("analog sel");
  analog_read_a: assert property (taken(8'h00, 1'b0) |=>
    (wb_dat_o[7:0] & analog_en_o) == 8'h00 && wb_dat_o[31:8] == 24'h0) else $error("analog pin read");
  reset_mode_a: assert property ($fell(rst_i) |-> analog_en_o == 8'hFF && pad_oe_n_o == 8'hFF)
    else $error("reset state wrong");
endmodule : bidir_port_chk
bind bidir_port bidir_port_chk bidir_port_chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .analog_en_o(analog_en_o));
`default_nettype wire

// ===== verif/pin_partner.sv
// outside circuit on the eight pins: drives each pin the port has released
// assumes the port drives a pin whenever its enable is low
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic [7:0] pad_out_i, // port drive levels
  input wire logic [7:0] pad_oe_n_i, // low where port drives
  input wire logic [7:0] ext_val_i, // level the circuit drives
  output logic [7:0] pin_o // resolved wire level
);
  // released pins follow the circuit, driven pins follow the port
  assign pin_o = (pad_oe_n_i & ext_val_i) | (~pad_oe_n_i & pad_out_i);
endmodule : pin_partner
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the eight-pin port with random settings
// assumes the checker is bound and the pin partner resolves the wires
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o, got_err;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00, ext_val = 8'h00, pins, pad_out_o, pad_oe_n_o, analog_en_o;
  logic [7:0] dir, lat, ana, pen, pdat, rd;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  int err_count = 0, num_checks = 0;
  bidir_port bidir_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pad_in_i(pins), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .analog_en_o(analog_en_o));
  pin_partner pin_partner_i (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .ext_val_i(ext_val), .pin_o(pins));
  // clock, 40 ns period
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // one classic wishbone cycle, entered just after a rising edge
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d, input logic s0);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= {3'h0, s0};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    rdat = wb_dat_o;
    got_err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      err_count++;
      conclude();
    end
    @(posedge clk_i);
  endtask : bus
  // expected drive level: enabled peripheral output wins over the latch
  function automatic logic [7:0] drv(input logic [7:0] d, l, pe, pd);
    return ((pe & ~d) & pd) | (~(pe & ~d) & l);
  endfunction : drv
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd = 8'($urandom(6));
    chk("analog after reset", analog_en_o, 8'hFF);
    chk("drivers after reset", pad_oe_n_o, 8'hFF);
    bus(1'b1, 8'h18, 8'h00, 1'b1);
    chk("unmapped write error", {31'h0, got_err}, 32'h1);
    bus(1'b0, 8'h04, 8'h00, 1'b1);
    chk("direction reset", rdat, 32'h000000FF);
    bus(1'b0, 8'h0C, 8'h00, 1'b1);
    chk("analog select reset", rdat, 32'h000000FF);
    bus(1'b0, 8'h18, 8'h00, 1'b1);
    chk("unmapped error", {31'h0, got_err}, 32'h1);
    for (int k = 0; k < 30; k++) begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      ana = 8'($urandom);
      pen = (k < 10) ? 8'h00 : 8'($urandom);
      pdat = 8'($urandom);
      if (k[0]) dir = dir | ana;
      if (k[1]) ana = 8'h00;
      if (k == 4) begin
        dir = 8'h00;
        ana = 8'hFF;
      end
      ext_val <= 8'($urandom);
      bus(1'b1, 8'h04, dir, 1'b1);
      bus(1'b1, 8'h08, lat, 1'b1);
      bus(1'b1, 8'h0C, ana, 1'b1);
      bus(1'b1, 8'h10, pen, 1'b1);
      bus(1'b1, 8'h14, pdat, 1'b1);
      chk("drive enable", pad_oe_n_o, dir);
      chk("drive level", pad_out_o, drv(dir, lat, pen, pdat));
      rd = (dir & ext_val) | (~dir & drv(dir, lat, pen, pdat));
      repeat (2) @(posedge clk_i);
      bus(1'b0, 8'h00, 8'h00, 1'b1);
      chk("pin read", rdat, {24'h0, rd & ~ana});
      bus(1'b1, 8'h0C, ~ana, 1'b0);
      bus(1'b0, 8'h0C, 8'h00, 1'b1);
      chk("analog select readback", rdat, {24'h0, ana});
      chk("mapped answer", {31'h0, got_err}, 32'h0);
      bus(1'b0, 8'h10, 8'h00, 1'b1);
      chk("periph enable readback", rdat, {24'h0, pen});
      bus(1'b0, 8'h14, 8'h00, 1'b1);
      chk("periph data readback", rdat, {24'h0, pdat});
      if (k % 3 == 0) begin
        bus(1'b1, 8'h00, 8'h00, 1'b0);
        bus(1'b0, 8'h08, 8'h00, 1'b1);
        chk("modify latch", rdat, {24'h0, rd & ~ana});
      end else begin
        bus(1'b1, 8'h00, pdat ^ lat, 1'b1);
        bus(1'b0, 8'h08, 8'h00, 1'b1);
        chk("port write latch", rdat, {24'h0, pdat ^ lat});
      end
    end
    // second reset after the loop: inputs and analog mode come back
    bus(1'b1, 8'h04, 8'h00, 1'b1);
    bus(1'b1, 8'h0C, 8'h00, 1'b1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("analog after second reset", analog_en_o, 8'hFF);
    chk("drivers after second reset", pad_oe_n_o, 8'hFF);
    bus(1'b0, 8'h0C, 8'h00, 1'b1);
    chk("analog select second reset", rdat, 32'h000000FF);
    conclude();
  end
endmodule : tb
`default_nettype wire
